/* File: hw/ees_master.sv */
/*
 Master end: turns byte-level commands (start, stop, write byte, read
 byte) into bus waveforms; the bus clock is divided from clk.
 Assumes the user sequences commands as the memory protocol needs.
*/
`timescale 1ns/1ps
module ees_master #(
  parameter int QTR_CYC = ees_pkg::QTR_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  ees_link_if.master bus
);
  localparam int QW = $clog2(QTR_CYC + 1);

  ees_pkg::ees_mst_st_e st_q, st_d;
  logic [QW-1:0] qcnt_q, qcnt_d;
  logic [1:0] qph_q, qph_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [8:0] tx_q, tx_d, rx_q, rx_d;
  logic scl_q, scl_d, sda_q, sda_d;
  logic rv_q, rv_d, ra_q, ra_d;
  logic [7:0] rd_q, rd_d;
  logic [1:0] sda_s_q;
  logic qtick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], bus.sda};
    end
  end

  assign qtick = qcnt_q == QW'(QTR_CYC - 1);
  assign cmd_ready = st_q == ees_pkg::MS_IDLE;

  always_comb begin
    st_d = st_q;
    qcnt_d = qcnt_q;
    qph_d = qph_q;
    bcnt_d = bcnt_q;
    tx_d = tx_q;
    rx_d = rx_q;
    scl_d = scl_q;
    sda_d = sda_q;
    rv_d = 1'b0;
    ra_d = ra_q;
    rd_d = rd_q;
    if (st_q == ees_pkg::MS_IDLE) begin
      qcnt_d = '0;
      qph_d = 2'h0;
      bcnt_d = 4'h0;
      if (cmd_valid) begin
        case (cmd_op)
          ees_pkg::OP_START: st_d = ees_pkg::MS_START;
          ees_pkg::OP_STOP: st_d = ees_pkg::MS_STOP;
          ees_pkg::OP_WRITE: begin
            tx_d = {cmd_data, 1'b1};
            st_d = ees_pkg::MS_BITS;
          end
          default: begin
            // master acknowledges a read byte by pulling low
            tx_d = {8'hff, ~cmd_ack};
            st_d = ees_pkg::MS_BITS;
          end
        endcase
      end
    end else if (!qtick) begin
      qcnt_d = qcnt_q + 1'b1;
    end else begin
      qcnt_d = '0;
      qph_d = qph_q + 2'h1;
      case (st_q)
        ees_pkg::MS_START: begin
          case (qph_q)
            2'h0: sda_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b0;
            default: begin
              scl_d = 1'b0;
              st_d = ees_pkg::MS_IDLE;
            end
          endcase
        end
        ees_pkg::MS_STOP: begin
          case (qph_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default: st_d = ees_pkg::MS_IDLE;
          endcase
        end
        default: begin
          case (qph_q)
            2'h0: begin
              sda_d = tx_q[8];
              tx_d = {tx_q[7:0], 1'b1};
            end
            2'h1: scl_d = 1'b1;
            2'h2: rx_d = {rx_q[7:0], sda_s_q[1]};
            default: begin
              scl_d = 1'b0;
              bcnt_d = bcnt_q + 4'h1;
              if (bcnt_q == ees_pkg::BYTE_BITS) begin
                rv_d = 1'b1;
                rd_d = rx_q[8:1];
                ra_d = ~rx_q[0];
                st_d = ees_pkg::MS_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ees_pkg::MS_IDLE;
      qcnt_q <= '0;
      qph_q <= 2'h0;
      bcnt_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rv_q <= 1'b0;
      ra_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      qcnt_q <= qcnt_d;
      qph_q <= qph_d;
      bcnt_q <= bcnt_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      rv_q <= rv_d;
      ra_q <= ra_d;
      rd_q <= rd_d;
    end
  end

  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign rsp_ack = ra_q;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe_b = scl_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_b = sda_q;
endmodule

/* File: hw/ees_pulse_sync.sv */
/*
 Toggle-to-pulse synchroniser: carries an event from another clock domain.
 Assumes the source flips src_tgl once per event, events spaced by at
 least three destination clocks.
*/
`timescale 1ns/1ps
module ees_pulse_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic src_tgl,
  output logic pulse
);
  logic [2:0] s_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= 3'h0;
    end else begin
      s_q <= {s_q[1:0], src_tgl};
    end
  end

  assign pulse = s_q[2] ^ s_q[1];
endmodule

/* File: hw/ees_slave.sv */
/*
 Slave end of the serial memory: bus decoding on the link clock, a
 64-byte page buffer, the byte array and a programming timer on clk.
 Assumes lclk runs much faster than the bus clock so every bus edge is
 seen, and sup_rst is an asynchronous supervisor reset level.
*/
// How it works
// - Upper four address bits must equal 1010
// - Address bit zero: one reads, zero writes
// - Acknowledge address only on a match
// - Receiver pulls data low on ninth clock
// - Acknowledge every received byte when writing
// - Send eight bits, continue only on acknowledge
// - Master sends address, two address bytes, data
// - Stop after write starts programming, bus ignored
// - Up to 64 data bytes per page
// - Write increments only low page bits
// - Beyond 64 bytes the page position wraps
// - All buffered bytes committed in one cycle
// - Polling address refused while programming
// - Counter holds last accessed location plus one
// - Counter rolls from 4095 to zero
// - Current read: acknowledge, one byte, no ack
// - Random read: dummy write, repeated start, read
// - Each master acknowledge yields the next byte
// - Read increments across all address bits
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Supervisor reset aborts transfers, not programming
`timescale 1ns/1ps
module ees_slave #(
  parameter int ADDR_W = ees_pkg::ADDR_W,
  parameter int PAGE_W = ees_pkg::PAGE_W,
  parameter int PROG_CYC = ees_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic lclk,
  input wire logic sup_rst,
  output logic prog_busy,
  ees_link_if.slave bus
);
  localparam int PG = 2 ** PAGE_W;
  localparam int CW = $clog2(PROG_CYC + 1);

  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [1:0] rst_s_q;
  logic scl_rise, scl_fall, start_c, stop_c, sda_in, rst_s;

  ees_pkg::ees_slv_st_e st_q, st_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d, ack_q, ack_d, drv_q, drv_d, busy_q, busy_d, go_q, go_d;
  logic [1:0] nab_q, nab_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_W-PAGE_W-1:0] cpage_q, cpage_d;
  logic [7:0] pbuf_q [PG];
  logic [7:0] pbuf_d [PG];
  logic [PG-1:0] pval_q, pval_d;
  logic [7:0] mem_q [2 ** ADDR_W];
  logic [7:0] rd_byte;
  logic done_p, go_p;

  logic run_q, run_d, done_q, done_d;
  logic [CW-1:0] cnt_q, cnt_d;

  // Bus pins and supervisor reset cross into the link domain
  always_ff @(posedge lclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      rst_s_q <= 2'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      rst_s_q <= {rst_s_q[0], sup_rst};
    end
  end

  assign sda_in = sda_s_q[1];
  assign rst_s = rst_s_q[1];
  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start_c = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop_c = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  assign rd_byte = mem_q[addr_q];
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_b = ~drv_q;

  always_comb begin
    st_d = st_q;
    bcnt_d = bcnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    ack_d = ack_q;
    drv_d = drv_q;
    nab_d = nab_q;
    addr_d = addr_q;
    cpage_d = cpage_q;
    pbuf_d = pbuf_q;
    pval_d = pval_q;
    busy_d = busy_q;
    go_d = go_q;
    if (done_p) begin
      busy_d = 1'b0;
      pval_d = '0;
    end
    if (rst_s) begin
      // abort and refuse, running programming continues
      st_d = ees_pkg::SL_IDLE;
      drv_d = 1'b0;
      if (!busy_q) begin
        pval_d = '0;
      end
    end else if (stop_c) begin
      if ((st_q == ees_pkg::SL_RX || st_q == ees_pkg::SL_ACK_RX) && (|pval_q) && !busy_q) begin
        busy_d = 1'b1;
        go_d = ~go_q;
        cpage_d = addr_q[ADDR_W-1:PAGE_W];
      end
      st_d = ees_pkg::SL_IDLE;
      drv_d = 1'b0;
    end else if (start_c) begin
      st_d = ees_pkg::SL_ADDR;
      bcnt_d = 4'h0;
      drv_d = 1'b0;
      if (!busy_q) begin
        pval_d = '0;
      end
    end else begin
      case (st_q)
        ees_pkg::SL_ADDR, ees_pkg::SL_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_in};
            bcnt_d = bcnt_q + 4'h1;
          end else if (scl_fall && bcnt_q == ees_pkg::BYTE_BITS) begin
            if (st_q == ees_pkg::SL_ADDR) begin
              // pattern compare, no ack while busy
              if (sh_q[7:4] == ees_pkg::DEV_ID && !busy_q) begin
                drv_d = 1'b1;
                rw_d = sh_q[0];
                st_d = ees_pkg::SL_ACK_ADDR;
              end else begin
                st_d = ees_pkg::SL_IGNORE;
              end
            end else begin
              drv_d = 1'b1;
              st_d = ees_pkg::SL_ACK_RX;
              case (nab_q)
                2'h0: begin
                  addr_d[ADDR_W-1:8] = sh_q[ADDR_W-9:0];
                  nab_d = 2'h1;
                end
                2'h1: begin
                  addr_d[7:0] = sh_q;
                  nab_d = 2'h2;
                end
                default: begin
                  pbuf_d[addr_q[PAGE_W-1:0]] = sh_q;
                  pval_d[addr_q[PAGE_W-1:0]] = 1'b1;
                  addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 1'b1;
                end
              endcase
            end
          end
        end
        ees_pkg::SL_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_q) begin
              // first byte of a read, counter advances
              sh_d = rd_byte;
              drv_d = ~rd_byte[7];
              addr_d = addr_q + 1'b1;
              bcnt_d = 4'h1;
              st_d = ees_pkg::SL_TX;
            end else begin
              drv_d = 1'b0;
              bcnt_d = 4'h0;
              nab_d = 2'h0;
              st_d = ees_pkg::SL_RX;
            end
          end
        end
        ees_pkg::SL_ACK_RX: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            bcnt_d = 4'h0;
            st_d = ees_pkg::SL_RX;
          end
        end
        ees_pkg::SL_TX: begin
          if (scl_fall) begin
            if (bcnt_q == ees_pkg::BYTE_BITS) begin
              drv_d = 1'b0;
              st_d = ees_pkg::SL_ACK_TX;
            end else begin
              drv_d = ~sh_q[6];
              sh_d = {sh_q[6:0], 1'b0};
              bcnt_d = bcnt_q + 4'h1;
            end
          end
        end
        ees_pkg::SL_ACK_TX: begin
          if (scl_rise) begin
            // master ack is data low on ninth clock
            ack_d = ~sda_in;
          end else if (scl_fall) begin
            if (ack_q) begin
              sh_d = rd_byte;
              drv_d = ~rd_byte[7];
              addr_d = addr_q + 1'b1;
              bcnt_d = 4'h1;
              st_d = ees_pkg::SL_TX;
            end else begin
              st_d = ees_pkg::SL_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge lclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ees_pkg::SL_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      nab_q <= 2'h0;
      addr_q <= '0;
      cpage_q <= '0;
      pbuf_q <= '{default: 8'h00};
      pval_q <= '0;
      busy_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bcnt_q <= bcnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      drv_q <= drv_d;
      nab_q <= nab_d;
      addr_q <= addr_d;
      cpage_q <= cpage_d;
      pbuf_q <= pbuf_d;
      pval_q <= pval_d;
      busy_q <= busy_d;
      go_q <= go_d;
    end
  end

  // only the buffered bytes of the page committed when programming ends
  always_ff @(posedge lclk) begin
    if (done_p) begin
      for (int i = 0; i < PG; i++) begin
        if (pval_q[i]) begin
          mem_q[{cpage_q, PAGE_W'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  ees_pulse_sync u_go_sync (
    .clk(clk),
    .rst_b(rst_b),
    .src_tgl(go_q),
    .pulse(go_p)
  );

  ees_pulse_sync u_done_sync (
    .clk(lclk),
    .rst_b(rst_b),
    .src_tgl(done_q),
    .pulse(done_p)
  );

  // Programming timer on the system clock
  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    done_d = done_q;
    if (go_p) begin
      run_d = 1'b1;
      cnt_d = '0;
    end else if (run_q) begin
      if (cnt_q == CW'(PROG_CYC - 1)) begin
        run_d = 1'b0;
        done_d = ~done_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign prog_busy = run_q;
endmodule

/* File: pkg/ees_link_if.sv */
/*
 Two-wire link between master and slave ends. Each open-drain pin is an
 output, an active-low output enable and the resolved wire level.
 Assumes pull-ups: a wire nobody pulls low reads high.
*/
`timescale 1ns/1ps
interface ees_link_if;
  logic m_scl_o;
  logic m_scl_oe_b;
  logic m_sda_o;
  logic m_sda_oe_b;
  logic s_sda_o;
  logic s_sda_oe_b;
  logic scl;
  logic sda;

  assign scl = m_scl_oe_b | m_scl_o;
  assign sda = (m_sda_oe_b | m_sda_o) & (s_sda_oe_b | s_sda_o);

  modport master (output m_scl_o, output m_scl_oe_b, output m_sda_o, output m_sda_oe_b, input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe_b, input scl, input sda);
endinterface

/* File: pkg/ees_pkg.sv */
/*
 Shared constants and state types for the two-wire serial memory link:
 the slave end, the master end and the link checker.
 Assumes a 50 MHz system clock on both ends.
*/
package ees_pkg;
  localparam int CLK_NS = 20;
  localparam logic [3:0] DEV_ID = 4'ha;
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int T_WR_NS = 5000000;
  localparam int PROG_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SCL_NS = 2500;
  localparam int QTR_CYC = (T_SCL_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_STOP = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_ACK_ADDR = 3'b010,
    SL_RX = 3'b011,
    SL_ACK_RX = 3'b100,
    SL_TX = 3'b101,
    SL_ACK_TX = 3'b110,
    SL_IGNORE = 3'b111
  } ees_slv_st_e;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_START = 2'b01,
    MS_BITS = 2'b10,
    MS_STOP = 2'b11
  } ees_mst_st_e;
endpackage

/* File: verif/ees_link_asserts.sv */
/*
 Protocol checker for the two-wire memory link, tracking bits and bytes.
 Assumes the resolved wire levels and enables of the link interface.
*/
`timescale 1ns/1ps
module ees_link_asserts (
  input wire logic clk,
  input wire logic lclk,
  input wire logic rst_b,
  input wire logic sup_rst,
  input wire logic prog_busy,
  input wire logic m_sda_oe_b,
  input wire logic s_sda_oe_b,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, rw_q, ack_q, ign_q, done_q, wd_q;
  logic rw_d, ack_d, ign_d, done_d, wd_d;
  logic [3:0] bc_q, bc_d;
  logic [1:0] nb_q, nb_d;
  logic [7:0] sh_q, sh_d;
  logic rise, cond, stop;

  assign rise = scl & ~scl_q;
  assign cond = scl & scl_q & (sda ^ sda_q);
  assign stop = cond & sda;

  // Bit count, byte count and direction seen on the wire
  always_comb begin
    {bc_d, nb_d, sh_d} = {bc_q, nb_q, sh_q};
    {rw_d, ack_d, ign_d, done_d, wd_d} = {rw_q, ack_q, ign_q, done_q, wd_q};
    if (rise && bc_q == 4'h8) begin
      bc_d = 4'h0;
      nb_d = nb_q + {1'b0, nb_q != 2'h3};
      if (nb_q == 2'h0) begin
        rw_d = sh_q[0];
        ack_d = ~s_sda_oe_b;
        ign_d = s_sda_oe_b;
      end else if (rw_q && ack_q) begin
        done_d = sda;
      end else if (nb_q == 2'h3) begin
        wd_d = wd_q | ~s_sda_oe_b;
      end
    end else if (rise) begin
      bc_d = bc_q + 4'h1;
      sh_d = {sh_q[6:0], sda};
    end
    if (cond) begin
      {bc_d, nb_d, ign_d, done_d, wd_d} = '0;
    end
    if (sup_rst) begin
      ack_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_q, sda_q} <= 2'b11;
      {bc_q, nb_q, sh_q} <= '0;
      {rw_q, ack_q, ign_q, done_q, wd_q} <= '0;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      {bc_q, nb_q, sh_q} <= {bc_d, nb_d, sh_d};
      {rw_q, ack_q, ign_q, done_q, wd_q} <= {rw_d, ack_d, ign_d, done_d, wd_d};
    end
  end

  sequence s_ninth;
    rise && bc_q == 4'h8;
  endsequence
  sequence s_addr;
    s_ninth ##0 nb_q == 2'h0;
  endsequence
  sequence s_data;
    s_ninth ##0 (nb_q != 2'h0 && ack_q);
  endsequence

  a_sda_scl_low: assert property (@(posedge lclk) disable iff (!rst_b || sup_rst)
    $changed(s_sda_oe_b) |-> !scl) else $error("slave data moved with clock high");
  a_addr_match: assert property (@(posedge clk) disable iff (!rst_b)
    s_addr ##0 !s_sda_oe_b |-> sh_q[7:4] == ees_pkg::DEV_ID) else $error("foreign address acknowledged");
  a_mismatch_nack: assert property (@(posedge clk) disable iff (!rst_b)
    s_addr ##0 sh_q[7:4] != ees_pkg::DEV_ID |-> s_sda_oe_b) else $error("mismatch not released");
  a_ignore_rest: assert property (@(posedge clk) disable iff (!rst_b)
    ign_q |-> s_sda_oe_b) else $error("ignored transfer driven");
  a_busy_nack: assert property (@(posedge clk) disable iff (!rst_b)
    s_addr ##0 prog_busy |-> s_sda_oe_b) else $error("address acknowledged while busy");
  a_write_ack: assert property (@(posedge clk) disable iff (!rst_b)
    s_data ##0 !rw_q |-> !s_sda_oe_b) else $error("written byte not acknowledged");
  a_read_release: assert property (@(posedge clk) disable iff (!rst_b)
    s_data ##0 rw_q |-> s_sda_oe_b) else $error("slave held data in ack slot");
  a_nack_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    done_q |-> s_sda_oe_b) else $error("slave sent after no acknowledge");
  a_prog_start: assert property (@(posedge clk) disable iff (!rst_b)
    stop && wd_q |-> ##[1:60] prog_busy) else $error("programming not started");
  a_mst_ack_slot: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(m_sda_oe_b) && rw_q && ack_q && !done_q && nb_q != 2'h0 |-> !scl && bc_q == 4'h8)
    else $error("master drove data outside ack slot");
endmodule

/* File: verif/testbench.sv */
/*
 Self-checking bench: master and slave ends joined by one link.
 Assumes shortened divider and programming counts given at the instances.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, lclk, rst_b, sup_rst, prog_busy;
  logic cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack, rack, pol_ok;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data, rsp_data, rd;
  int num_errors, checks_done, npoll;
  // Address and data written, then read back
  logic [19:0] rows [5] = '{20'h12355, 20'h0003c, 20'h001c3, 20'hfffa5, 20'h60096};
  logic [7:0] bad [4] = '{8'h20, 8'he0, 8'hb1, 8'h0a};

  ees_link_if bus ();
  ees_master #(.QTR_CYC(12)) u_ees_master (.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_data,
    .cmd_ack, .rsp_valid, .rsp_data, .rsp_ack, .bus(bus.master));
  ees_slave #(.PROG_CYC(600)) u_ees_slave (.clk, .rst_b, .lclk, .sup_rst, .prog_busy, .bus(bus.slave));
  ees_link_asserts u_ees_link_asserts (.clk, .lclk, .rst_b, .sup_rst, .prog_busy,
    .m_sda_oe_b(bus.m_sda_oe_b), .s_sda_oe_b(bus.s_sda_oe_b), .scl(bus.scl), .sda(bus.sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [1:0] op, input logic [7:0] d, input logic a);
    int i = 0;
    cmd_op <= op;
    cmd_data <= d;
    cmd_ack <= a;
    cmd_valid <= 1'b1;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && i < 2000) begin
      @(negedge clk);
      i++;
    end
    chk("command ready", {7'h0, cmd_ready}, 8'h01);
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    if (op[1]) begin
      @(negedge clk);
      while (rsp_valid !== 1'b1 && i < 2000) begin
        @(negedge clk);
        i++;
      end
      chk("byte answered", {7'h0, rsp_valid}, 8'h01);
      rd = rsp_data;
      rack = rsp_ack;
    end
    @(posedge clk);
  endtask

  // Repeats start and address until acknowledged
  task automatic sel(input logic [7:0] a8);
    npoll = 0;
    do begin
      send(ees_pkg::OP_START, 8'h00, 1'b0);
      send(ees_pkg::OP_WRITE, a8, 1'b0);
      npoll++;
    end while (rack !== 1'b1 && npoll < 8);
    chk("address ack", {7'h0, rack}, 8'h01);
  endtask

  task automatic setaddr(input logic [11:0] a);
    sel(8'ha0);
    pol_ok = npoll > 1;
    send(ees_pkg::OP_WRITE, {4'h0, a[11:8]}, 1'b0);
    chk("high address ack", {7'h0, rack}, 8'h01);
    send(ees_pkg::OP_WRITE, a[7:0], 1'b0);
    chk("low address ack", {7'h0, rack}, 8'h01);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d0, input int n);
    setaddr(a);
    for (int i = 0; i < n; i++) begin
      send(ees_pkg::OP_WRITE, d0 + 8'(i), 1'b0);
      chk("data ack", {7'h0, rack}, 8'h01);
    end
    send(ees_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  // Acknowledges every byte but the last
  task automatic rdq(input logic rnd, input logic [11:0] a, input int n, input logic [7:0] e [3]);
    if (rnd)
      setaddr(a);
    sel(8'ha1);
    for (int i = 0; i < n; i++) begin
      send(ees_pkg::OP_READ, 8'h00, i < n - 1);
      chk("read data", rd, e[i]);
    end
    send(ees_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  initial begin
    {rst_b, sup_rst, cmd_valid, cmd_op, cmd_data, cmd_ack} = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("idle link", {4'h0, bus.scl, bus.sda, bus.s_sda_oe_b, cmd_ready}, 8'h0f);
    chk("busy in reset", {7'h0, prog_busy}, 8'h00);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge lclk);
    @(posedge clk);
    foreach (rows[r]) begin
      wr(rows[r][19:8], rows[r][7:0], 1);
      rdq(1'b1, rows[r][19:8], 1, '{rows[r][7:0], 8'h00, 8'h00});
      chk("busy poll", {7'h0, pol_ok}, 8'h01);
    end
    wr(12'h5fe, 8'h80, 65);
    rdq(1'b1, 12'h5fe, 3, '{8'hc0, 8'h81, 8'h96});
    rdq(1'b1, 12'hfff, 2, '{8'ha5, 8'h3c, 8'h00});
    rdq(1'b0, 12'h000, 1, '{8'hc3, 8'h00, 8'h00});
    foreach (bad[b]) begin
      send(ees_pkg::OP_START, 8'h00, 1'b0);
      send(ees_pkg::OP_WRITE, bad[b], 1'b0);
      chk("foreign address", {7'h0, rack}, 8'h00);
    end
    send(ees_pkg::OP_STOP, 8'h00, 1'b0);
    wr(12'h777, 8'h69, 1);
    // Let the stop finish so programming starts before the supervisor reset
    repeat (60) @(posedge clk);
    sup_rst <= 1'b1;
    send(ees_pkg::OP_START, 8'h00, 1'b0);
    send(ees_pkg::OP_WRITE, 8'ha0, 1'b0);
    chk("refused in reset", {7'h0, rack}, 8'h00);
    chk("programming kept", {7'h0, prog_busy}, 8'h01);
    send(ees_pkg::OP_STOP, 8'h00, 1'b0);
    // Programming over, reset still held: the refusal must come from the reset
    repeat (150) @(posedge clk);
    chk("idle in reset", {7'h0, prog_busy}, 8'h00);
    send(ees_pkg::OP_START, 8'h00, 1'b0);
    send(ees_pkg::OP_WRITE, 8'ha0, 1'b0);
    chk("refused when idle", {7'h0, rack}, 8'h00);
    send(ees_pkg::OP_STOP, 8'h00, 1'b0);
    sup_rst <= 1'b0;
    repeat (20) @(posedge clk);
    rdq(1'b1, 12'h777, 1, '{8'h69, 8'h00, 8'h00});
    test_done();
  end

  initial begin
    #1_900_000;
    num_errors++;
    test_done();
  end
endmodule
